/* ias_assertions.sv */
module ias_checker
  import ias_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_arm_in,
  input wire logic start_arm,
  input wire logic stop_arm
);
  logic [31:0] ctrl_q;
  logic go_seen;
  logic ext_q;
  logic [3:0] age;
  logic wr_ctrl;
  logic sel_edge;
  logic [31:0] code_exp;
  assign wr_ctrl = psel && penable && pwrite && paddr == ias_ctrl_off;
  // Pin edge age, not synced edge: bound covers the synchroniser delay
  assign sel_edge = ctrl_q[ias_b_sta_neg] ? (ext_q & ~ext_arm_in) : (~ext_q & ext_arm_in);
  assign code_exp = ctrl_q[3:2] == ias_src_time ? {24'h0, ias_asc_tim} :
      ctrl_q[3:2] == ias_src_event ? {16'h0, ias_asc_int, ias_asc_imm} : {24'h0, ias_asc_imm};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ias_ctrl_rst;
      go_seen <= 1'b0;
      ext_q <= 1'b0;
      age <= 4'hf;
    end else begin
      if (wr_ctrl) ctrl_q <= pwdata;
      if (wr_ctrl) go_seen <= pwdata[ias_b_go] | (go_seen & ~pwdata[ias_b_abort]);
      ext_q <= ext_arm_in;
      if (sel_edge) age <= 4'h0;
      else if (age != 4'hf) age <= age + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_go_imm;
    wr_ctrl && pwdata[ias_b_go] && !pwdata[ias_b_sta_ext] && pwdata[3:2] == ias_src_none;
  endsequence
  a_pready_high: assert property (s_acc |-> pready) else $error("pready low");
  a_slverr_map: assert property (s_acc |-> pslverr == (paddr > ias_code_off || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  a_imm_start: assert property (s_go_imm |-> ##[1:8] start_arm)
    else $error("immediate start late");
  a_ext_edge: assert property ($rose(start_arm) && ctrl_q[ias_b_sta_ext] && ctrl_q[3:2] == ias_src_none |-> age < 4'hc)
    else $error("start armed off edge");
  a_go_first: assert property ($rose(start_arm) |-> go_seen)
    else $error("armed without go");
  a_stop_order: assert property ($rose(stop_arm) |-> start_arm)
    else $error("stop before start");
  a_pulse_nostop: assert property ($rose(stop_arm) |-> !ctrl_q[ias_b_pulse])
    else $error("stop armed in pulse mode");
  a_code_read: assert property (psel && penable && !pwrite && paddr == ias_code_off |-> prdata == code_exp)
    else $error("source code wrong");
endmodule // ias_checker

bind interval_arm_sequencer ias_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_arm_in(ext_arm_in), .start_arm(start_arm),
  .stop_arm(stop_arm));

/* ias_chain.sv */
module ias_chain
  import ias_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic abort,
  input wire logic ext_sel,
  input wire logic neg_edge,
  input wire logic [1:0] src,
  input wire logic [26:0] event_delay_count,
  input wire logic [31:0] ticks,
  input wire logic ext_rise,
  input wire logic ext_fall,
  input wire logic event_in,
  input wire logic tick,
  output logic armed,
  output ias_pkg::ias_state_t state
);
  logic [31:0] cnt;
  logic edge_hit;
  assign edge_hit = neg_edge ? ext_fall : ext_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ias_idle;
      cnt <= 32'h0000_0000;
      armed <= 1'b0;
    end else if (abort) begin
      state <= ias_idle;
      armed <= 1'b0;
    end else begin
      case (state)
        ias_idle: if (start) begin
          armed <= 1'b0;
          state <= ias_outer;
        end
        ias_outer: if (!ext_sel || edge_hit) begin
          cnt <= (src == ias_src_event) ? {5'h00, event_delay_count} : ticks;
          state <= ias_inner;
        end
        ias_inner: begin
          if (src == ias_src_none || cnt == 32'h0000_0000) begin
            armed <= 1'b1;
            state <= ias_done;
          end else if ((src == ias_src_event && event_in) ||
                       (src == ias_src_time && tick)) begin
            cnt <= cnt - 32'h0000_0001;
          end
        end
        ias_done: if (start) begin
          armed <= 1'b0;
          state <= ias_outer;
        end
        default: state <= ias_idle;
      endcase
    end
  end
endmodule // ias_chain

/* ias_edge_sync.sv */
module ias_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic rise,
  output logic fall
);
  logic meta;
  logic sync;
  logic prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;
endmodule // ias_edge_sync

/* ias_far_end.sv */
module ias_far_end (
  input wire logic pclk,
  output logic ext_arm_in,
  output logic start_event_source,
  output logic stop_event_source
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_arm_in = 1'b0;
    start_event_source = 1'b0;
    stop_event_source = 1'b0;
  end
  // Level held long enough for the two-flop synchroniser
  task automatic arm_level(input logic v);
    @(posedge pclk);
    ext_arm_in <= v;
    repeat (4) @(posedge pclk);
  endtask
  task automatic events(input bit stop, input int n, input int gap);
    repeat (n) begin
      @(posedge pclk);
      if (stop) stop_event_source <= 1'b1;
      else start_event_source <= 1'b1;
      repeat (3) @(posedge pclk);
      start_event_source <= 1'b0;
      stop_event_source <= 1'b0;
      repeat (gap) @(posedge pclk);
    end
  endtask
endmodule // ias_far_end

/* ias_pkg.sv */
package ias_pkg;
  localparam int unsigned ias_clk_hz = 125000000;
  // Delay timebase tick
  localparam int unsigned ias_tick_ns = 100;
  localparam int unsigned ias_clk_ns = 8;
  localparam logic [3:0] ias_tick_cycles = 4'(ias_tick_ns / ias_clk_ns);
  // Long stop delay steps in 0.96 ms (10000 ticks of 96 ns)
  localparam logic [31:0] ias_ms_ticks = 32'h0000_2710;
  localparam logic [26:0] ias_event_delay_count_max = 27'h5f5_e0ff;
  localparam logic [26:0] ias_event_delay_count_rst = 27'h000_0001;
  localparam logic [23:0] ias_time_max = 24'h98_967f;
  localparam logic [23:0] ias_time_rst = 24'h00_0001;
  localparam logic [13:0] ias_long_min = 14'h03e8;
  localparam logic [13:0] ias_long_max = 14'h2710;
  localparam logic [13:0] ias_long_rst = 14'h0000;
  // Register offsets
  localparam logic [7:0] ias_ctrl_off = 8'h00;
  localparam logic [7:0] ias_sta_event_delay_count_off = 8'h04;
  localparam logic [7:0] ias_sta_time_off = 8'h08;
  localparam logic [7:0] ias_sto_event_delay_count_off = 8'h0c;
  localparam logic [7:0] ias_sto_time_off = 8'h10;
  localparam logic [7:0] ias_sto_long_off = 8'h14;
  localparam logic [7:0] ias_status_off = 8'h18;
  localparam logic [7:0] ias_code_off = 8'h1c;
  // Control bit positions
  localparam int unsigned ias_b_sta_ext = 0;
  localparam int unsigned ias_b_sta_neg = 1;
  localparam int unsigned ias_b_sta_src = 2;
  localparam int unsigned ias_b_sto_ext = 4;
  localparam int unsigned ias_b_sto_neg = 5;
  localparam int unsigned ias_b_sto_src = 6;
  localparam int unsigned ias_b_pulse = 8;
  localparam int unsigned ias_b_go = 9;
  localparam int unsigned ias_b_abort = 10;
  localparam logic [31:0] ias_ctrl_rst = 32'h0000_0000;
  // Inner layer sources
  localparam logic [1:0] ias_src_none = 2'h0;
  localparam logic [1:0] ias_src_time = 2'h1;
  localparam logic [1:0] ias_src_event = 2'h2;
  // ASCII query codes
  localparam logic [7:0] ias_asc_imm = 8'h49;
  localparam logic [7:0] ias_asc_tim = 8'h54;
  localparam logic [7:0] ias_asc_int = 8'h31;
  typedef enum logic [1:0] {ias_idle, ias_outer, ias_inner, ias_done} ias_state_t;
endpackage

/* interval_arm_sequencer.sv */
// Operation
// - Start outer layer picks immediate or external arm, immediate after reset.
// - Start external edge is rising or falling, rising by default, used if external.
// - Start inner layer: none, time or start event count; none by default.
// - Start event delay counts 1 to 99,999,999 events, default 1.
// - Start time delay 96 ns to 0.959999904 s in 96 ns steps (12 clocks), default 96 ns.
// - Start inner layer settings are ignored for pulse-type measurements.
// - Stop outer layer picks immediate or external arm, immediate after reset.
// - Stop external edge is rising or falling, rising by default, used if external.
// - With external start every inner and stop combination is accepted.
// - Pulse-type measurements arm from the start outer layer alone.
// - Query reports inner start source as ASCII code, counts as integers.
// - Stop inner layer: none, time or stop event count; none; ignored for pulses.
// - Stop event delay counts 1 to 99,999,999 events, default 1.
// - Stop time 96 ns steps to 0.959999904 s, or 0.96 to 9.6 s in 0.96 ms steps.
module interval_arm_sequencer
  import ias_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_arm_in,
  input wire logic start_event_source,
  input wire logic stop_event_source,
  output logic start_arm,
  output logic stop_arm
);
  logic [31:0] ctrl;
  logic [26:0] sta_event_delay_count;
  logic [23:0] sta_time;
  logic [26:0] sto_event_delay_count;
  logic [23:0] sto_time;
  logic [13:0] sto_long;
  logic [3:0] tick_div;
  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic sta_ev_meta;
  logic sta_ev_sync;
  logic sta_ev_prev;
  logic sto_ev_meta;
  logic sto_ev_sync;
  logic sto_ev_prev;
  logic go;
  logic abort;
  logic wr;
  logic rd_hit;
  logic pulse_mode;
  logic [1:0] sta_src_eff;
  logic sto_ext_eff;
  logic [1:0] sto_src_eff;
  logic sta_armed;
  logic sto_armed;
  logic sto_start;
  logic [31:0] sto_ticks;
  ias_state_t sta_state;
  ias_state_t sto_state;

  function automatic logic [26:0] clamp_count(input logic [31:0] v);
    if (v[30:0] == 31'h0000_0000) clamp_count = 27'h000_0001;
    else if (v > {5'h00, ias_event_delay_count_max}) clamp_count = ias_event_delay_count_max;
    else clamp_count = v[26:0];
  endfunction

  function automatic logic [23:0] clamp_time(input logic [31:0] v);
    if (v == 32'h0000_0000) clamp_time = 24'h00_0001;
    else if (v > {8'h00, ias_time_max}) clamp_time = ias_time_max;
    else clamp_time = v[23:0];
  endfunction

  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign rd_hit = (paddr <= ias_code_off) && (paddr[1:0] == 2'h0);
  assign pslverr = psel & penable & ~rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ias_ctrl_rst;
    end else if (wr && paddr == ias_ctrl_off) begin
      // Go and abort are self-clearing, never stored
      ctrl <= {21'h000000, 2'h0, pwdata[8:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sta_event_delay_count <= ias_event_delay_count_rst;
      sta_time <= ias_time_rst;
      sto_event_delay_count <= ias_event_delay_count_rst;
      sto_time <= ias_time_rst;
      sto_long <= ias_long_rst;
    end else if (wr) begin
      case (paddr)
        ias_sta_event_delay_count_off: sta_event_delay_count <= clamp_count(pwdata);
        ias_sta_time_off: sta_time <= clamp_time(pwdata);
        ias_sto_event_delay_count_off: sto_event_delay_count <= clamp_count(pwdata);
        ias_sto_time_off: begin
          sto_time <= clamp_time(pwdata);
          sto_long <= ias_long_rst;
        end
        ias_sto_long_off: begin
          // Long stop delay in 0.96 ms units; writes below 1000 clamp to 1000, a stored zero (reset or stop time write) selects the short delay
          if (pwdata[13:0] < ias_long_min) sto_long <= ias_long_min;
          else if (pwdata[13:0] > ias_long_max || pwdata[31:14] != 18'h00000)
            sto_long <= ias_long_max;
          else sto_long <= pwdata[13:0];
        end
        default: ;
      endcase
    end
  end

  assign go = wr && paddr == ias_ctrl_off && pwdata[ias_b_go];
  assign abort = wr && paddr == ias_ctrl_off && pwdata[ias_b_abort];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 4'h0;
      tick <= 1'b0;
    end else if (tick_div == ias_tick_cycles - 4'h1) begin
      tick_div <= 4'h0;
      tick <= 1'b1;
    end else begin
      tick_div <= tick_div + 4'h1;
      tick <= 1'b0;
    end
  end

  ias_edge_sync u_ext (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(ext_arm_in),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  // Event inputs are asynchronous pins: sync then count rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sta_ev_meta <= 1'b0;
      sta_ev_sync <= 1'b0;
      sta_ev_prev <= 1'b0;
      sto_ev_meta <= 1'b0;
      sto_ev_sync <= 1'b0;
      sto_ev_prev <= 1'b0;
    end else begin
      sta_ev_meta <= start_event_source;
      sta_ev_sync <= sta_ev_meta;
      sta_ev_prev <= sta_ev_sync;
      sto_ev_meta <= stop_event_source;
      sto_ev_sync <= sto_ev_meta;
      sto_ev_prev <= sto_ev_sync;
    end
  end

  assign pulse_mode = ctrl[ias_b_pulse];
  assign sta_src_eff = pulse_mode ? ias_src_none : ctrl[ias_b_sta_src +: 2];
  assign sto_ext_eff = pulse_mode ? 1'b0 : ctrl[ias_b_sto_ext];
  assign sto_src_eff = pulse_mode ? ias_src_none : ctrl[ias_b_sto_src +: 2];
  // Stop chain is released once start has armed, except in pulse mode
  assign sto_start = sta_armed && sto_state == ias_idle && !pulse_mode;
  assign sto_ticks = (sto_long != ias_long_rst) ?
    32'(sto_long) * ias_ms_ticks : {8'h00, sto_time};

  ias_chain u_start (
    .pclk(pclk),
    .presetn(presetn),
    .start(go),
    .abort(abort),
    .ext_sel(ctrl[ias_b_sta_ext]),
    .neg_edge(ctrl[ias_b_sta_neg]),
    .src(sta_src_eff),
    .event_delay_count(sta_event_delay_count),
    .ticks({8'h00, sta_time}),
    .ext_rise(ext_rise),
    .ext_fall(ext_fall),
    .event_in(sta_ev_sync & ~sta_ev_prev),
    .tick(tick),
    .armed(sta_armed),
    .state(sta_state)
  );

  ias_chain u_stop (
    .pclk(pclk),
    .presetn(presetn),
    .start(sto_start | (go & sto_state != ias_idle)),
    .abort(abort | go),
    .ext_sel(sto_ext_eff),
    .neg_edge(ctrl[ias_b_sto_neg]),
    .src(sto_src_eff),
    .event_delay_count(sto_event_delay_count),
    .ticks(sto_ticks),
    .ext_rise(ext_rise),
    .ext_fall(ext_fall),
    .event_in(sto_ev_sync & ~sto_ev_prev),
    .tick(tick),
    .armed(sto_armed),
    .state(sto_state)
  );

  assign start_arm = sta_armed;
  assign stop_arm = sto_armed & ~pulse_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ias_ctrl_off: prdata <= ctrl;
        ias_sta_event_delay_count_off: prdata <= {5'h00, sta_event_delay_count};
        ias_sta_time_off: prdata <= {8'h00, sta_time};
        ias_sto_event_delay_count_off: prdata <= {5'h00, sto_event_delay_count};
        ias_sto_time_off: prdata <= {8'h00, sto_time};
        ias_sto_long_off: prdata <= {18'h00000, sto_long};
        ias_status_off: prdata <= {26'h0000000, sto_armed, sta_armed, sto_state, sta_state};
        ias_code_off: begin
          case (ctrl[ias_b_sta_src +: 2])
            ias_src_time: prdata <= {24'h000000, ias_asc_tim};
            ias_src_event: prdata <= {16'h0000, ias_asc_int, ias_asc_imm + 8'h00};
            default: prdata <= {24'h000000, ias_asc_imm};
          endcase
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // interval_arm_sequencer

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ias_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic ext_arm_in, sev, tev, start_arm, stop_arm, e;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] dflt [8] = '{ias_ctrl_rst, 32'(ias_event_delay_count_rst), 32'(ias_time_rst),
      32'(ias_event_delay_count_rst), 32'(ias_time_rst), 32'(ias_long_rst), 32'h0, 32'(ias_asc_imm)};
  logic [31:0] codes [3] = '{32'(ias_asc_imm), 32'(ias_asc_tim), {16'h0, ias_asc_int, ias_asc_imm}};
  interval_arm_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_arm_in(ext_arm_in), .start_event_source(sev),
    .stop_event_source(tev), .start_arm(start_arm), .stop_arm(stop_arm));
  ias_far_end i_far (.pclk(pclk), .ext_arm_in(ext_arm_in), .start_event_source(sev),
    .stop_event_source(tev));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(32'h1, 32'h0);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
    chk({31'h0, e}, 32'h0);
  endtask
  function automatic logic armed(input bit s);
    return s ? stop_arm : start_arm;
  endfunction
  task automatic wait_arm(input bit s, input int n);
    while (armed(s) !== 1'b1 && n > 0) begin
      @(posedge pclk);
      n--;
    end
    chk({31'h0, armed(s)}, 32'h1);
    if (n == 0) report_and_stop();
  endtask
  task automatic quiet(input bit s, input int n);
    repeat (n) begin
      @(posedge pclk);
      chk({31'h0, armed(s)}, 32'h0);
    end
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), dflt[i]);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(ias_sta_event_delay_count_off, 32'h0);
    rd(ias_sta_event_delay_count_off, 32'h1);
    wr(ias_sta_event_delay_count_off, 32'h05f5_e100);
    rd(ias_sta_event_delay_count_off, 32'(ias_event_delay_count_max));
    wr(ias_sta_time_off, 32'h0098_9680);
    rd(ias_sta_time_off, 32'(ias_time_max));
    for (int i = 0; i < 3; i++) begin
      wr(ias_ctrl_off, 32'(i) << 2);
      rd(ias_code_off, codes[i]);
    end
    $display("test registers done");
    wr(ias_ctrl_off, 32'h200);
    wait_arm(0, 20);
    wait_arm(1, 20);
    rd(ias_status_off, 32'h3f);
    $display("test immediate done");
    wr(ias_sta_event_delay_count_off, 32'h3);
    wr(ias_ctrl_off, 32'h239);
    rd(ias_status_off, 32'h01);
    i_far.events(0, 2, 2);
    quiet(0, 8);
    i_far.arm_level(1'b1);
    i_far.events(0, 2, 2);
    quiet(0, 8);
    i_far.events(0, 1, 2);
    wait_arm(0, 30);
    quiet(1, 8);
    i_far.arm_level(1'b0);
    wait_arm(1, 20);
    $display("test event delay done");
    wr(ias_sta_time_off, 32'h5);
    wr(ias_sto_event_delay_count_off, 32'h2);
    wr(ias_ctrl_off, 32'h285);
    i_far.arm_level(1'b1);
    quiet(0, 30);
    wait_arm(0, 80);
    quiet(1, 6);
    i_far.events(1, 1, 5);
    quiet(1, 4);
    i_far.events(1, 1, 5);
    wait_arm(1, 30);
    $display("test time delay done");
    i_far.arm_level(1'b0);
    wr(ias_ctrl_off, 32'h389);
    i_far.arm_level(1'b1);
    wait_arm(0, 20);
    quiet(1, 20);
    $display("test pulse done");
    i_far.arm_level(1'b0);
    wr(ias_ctrl_off, 32'h203);
    i_far.arm_level(1'b1);
    quiet(0, 10);
    i_far.arm_level(1'b0);
    wait_arm(0, 20);
    wait_arm(1, 20);
    $display("test falling edge done");
    report_and_stop();
  end
endmodule // tb
